// [design/aesl_top.sv]
// design: per-axis emergency-stop cause latch with APB register access
// Function
// [RULE_01] summary bit 15 set with any cause
// [RULE_02] feedback loss latches code 8001
// [RULE_03] excess following error latches code 8002
// [RULE_04] follower delta overflow latches code 8004
// [RULE_05] overflow when product exceeds 31 bits
// [RULE_06] overflow when scaled move exceeds 16 bits
// [RULE_07] stop command latches code 8008
// [RULE_08] networked drive status bit 13 latches 8010
// [RULE_09] networked sync loss latches code 8020
// [RULE_10] simultaneous causes are ORed together
// [RULE_11] stepper command zeroed on any stop
// [RULE_12] stepper never raises feedback or following
// [RULE_13] reset clears condition and all causes
// [RULE_14] condition held until reset command
// [RULE_15] resumable stop keeps queues on reset
// [RULE_16] non-resumable stop flushes queues on reset
// [RULE_17] reset recloses loop if previously closed
// [RULE_18] stop opens loop and zeroes output
// [RULE_19] resume permission puts axis in resume
// [RULE_20] digitizing axis: feedback loss only cause
// [RULE_21] single-cycle commands acknowledged same cycle
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module aesl_top #(
    parameter int AXES = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control program commands
    input wire aesl_pkg::aesl_cmd_type cmd,
    output logic cmd_done,
    // motion core
    input wire aesl_pkg::aesl_meas_type [AXES-1:0] meas,
    output aesl_pkg::aesl_drive_type [AXES-1:0] drive
);

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] sel_ff;
    logic [2:0] cfg_ff [AXES];
    logic [31:0] limit_ff [AXES];
    logic [15:0] cause_ff [AXES];
    logic resumable_ff [AXES];
    logic loop_ff [AXES];
    logic loop_before_ff [AXES];
    logic flush_ff [AXES];
    logic [31:0] prdata_ff;
    logic slverr_ff;
    logic access;
    logic wr;
    logic sel_ok;
    logic cmd_ok;

    assign access = psel & penable;
    assign wr = access & pwrite;
    assign sel_ok = (sel_ff < 8'(AXES));
    assign cmd_ok = (cmd.axis < 8'(AXES));
    assign pready = 1'b1; // zero-wait slave
    assign prdata = prdata_ff;
    assign pslverr = slverr_ff;
    // acknowledge stands in the same cycle as the accepted pulse
    assign cmd_done = (cmd.stop | cmd.reset) & cmd_ok; // [RULE_21]

    // axis selector for the windowed per-axis registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_ff <= 8'h00;
        end else if (wr && paddr == aesl_pkg::ADDR_AXIS_SEL) begin
            sel_ff <= pwdata[7:0];
        end
    end

    // read data mux, registered at the setup cycle for the access edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
            case (paddr)
                aesl_pkg::ADDR_CAUSE_WORD: begin
                    if (sel_ok) begin
                        prdata_ff <= {16'h0000, cause_ff[sel_ff[$clog2(AXES)-1:0]]};
                    end
                end
                aesl_pkg::ADDR_AXIS_CFG: begin
                    if (sel_ok) begin
                        prdata_ff <= {29'h0000_0000, cfg_ff[sel_ff[$clog2(AXES)-1:0]]};
                    end
                end
                aesl_pkg::ADDR_AXIS_STAT: begin
                    if (sel_ok) begin
                        prdata_ff <= {28'h000_0000,
                            flush_ff[sel_ff[$clog2(AXES)-1:0]],
                            resumable_ff[sel_ff[$clog2(AXES)-1:0]],
                            loop_ff[sel_ff[$clog2(AXES)-1:0]],
                            cause_ff[sel_ff[$clog2(AXES)-1:0]][aesl_pkg::BIT_SUMMARY]};
                    end
                end
                aesl_pkg::ADDR_FOLLOW_LIMIT: begin
                    if (sel_ok) begin
                        prdata_ff <= limit_ff[sel_ff[$clog2(AXES)-1:0]];
                    end
                end
                aesl_pkg::ADDR_AXIS_SEL: begin
                    prdata_ff <= {24'h00_0000, sel_ff};
                end
                default: begin
                    slverr_ff <= 1'b1; // unmapped address
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-axis latch

    for (genvar a = 0; a < AXES; a++) begin : g_axis
        aesl_pkg::aesl_kind_type kind;
        logic hit;
        logic stop_cmd;
        logic reset_cmd;
        logic signed [63:0] product;
        logic signed [63:0] scaled;
        logic signed [32:0] gap;
        logic [32:0] gap_abs;
        logic ovf_big;
        logic ovf_scaled;
        logic [15:0] raw;
        logic [15:0] allowed;
        logic [15:0] nxt_cause;

        assign kind = aesl_pkg::aesl_kind_type'(cfg_ff[a][aesl_pkg::CFG_KIND_LSB +: 2]);
        assign hit = cmd_ok && cmd.axis[$clog2(AXES)-1:0] == ($clog2(AXES))'(a);
        assign stop_cmd = cmd.stop & hit;
        assign reset_cmd = cmd.reset & hit;

        // overflow detection on follower motion
        always_comb begin
            product = 64'(meas[a].leader_moved) * 64'(meas[a].follower_distance);
            scaled = 64'sh0;
            if (meas[a].leader_distance != 32'sh0) begin
                scaled = product / 64'(meas[a].leader_distance);
            end
            ovf_big = (product > 64'sh3FFF_FFFF) || (product < -64'sh4000_0000); // [RULE_05]
            ovf_scaled = (scaled > 64'sh7FFF) || (scaled < -64'sh8000); // [RULE_06]
        end

        // following error magnitude
        always_comb begin
            gap = 33'(meas[a].commanded_pos) - 33'(meas[a].actual_pos);
            gap_abs = gap[32] ? 33'(-gap) : gap;
        end

        // raw cause detection
        always_comb begin
            raw = 16'h0000;
            raw[aesl_pkg::BIT_FEEDBACK] = meas[a].feedback_lost; // [RULE_02]
            raw[aesl_pkg::BIT_FOLLOW] = gap_abs > {1'b0, limit_ff[a]}; // [RULE_03]
            raw[aesl_pkg::BIT_OVERFLOW] = meas[a].follower_active
                & (ovf_big | ovf_scaled); // [RULE_04]
            raw[aesl_pkg::BIT_USER] = stop_cmd; // [RULE_07]
            raw[aesl_pkg::BIT_DRIVE] = meas[a].drive_status[aesl_pkg::DRIVE_STOP_BIT]; // [RULE_08]
            raw[aesl_pkg::BIT_SYNC] = meas[a].sync_lost; // [RULE_09]
        end

        // causes permitted per axis kind
        always_comb begin
            case (kind)
                aesl_pkg::AESL_DIGITIZING: allowed = 16'h0001; // [RULE_20]
                aesl_pkg::AESL_STEPPER: allowed = 16'h003C; // [RULE_12]
                aesl_pkg::AESL_NETWORKED: allowed = 16'h003F;
                default: allowed = 16'h000F;
            endcase
        end

        // latch: new causes win over a reset in the same cycle
        always_comb begin
            nxt_cause = reset_cmd ? aesl_pkg::CAUSE_RESET : cause_ff[a]; // [RULE_13]
            nxt_cause[7:0] = nxt_cause[7:0] | (raw[7:0] & allowed[7:0]); // [RULE_10]
            nxt_cause[aesl_pkg::BIT_SUMMARY] = |nxt_cause[7:0]; // [RULE_01]
        end

        // cause word holds until reset
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cause_ff[a] <= aesl_pkg::CAUSE_RESET;
            end else begin
                cause_ff[a] <= nxt_cause; // [RULE_14]
            end
        end

        // per-axis configuration registers
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cfg_ff[a] <= aesl_pkg::CFG_RESET;
                limit_ff[a] <= aesl_pkg::LIMIT_RESET;
            end else if (wr && sel_ok && sel_ff[$clog2(AXES)-1:0] == ($clog2(AXES))'(a)) begin
                if (paddr == aesl_pkg::ADDR_AXIS_CFG) begin
                    cfg_ff[a] <= pwdata[2:0];
                end
                if (paddr == aesl_pkg::ADDR_FOLLOW_LIMIT) begin
                    limit_ff[a] <= pwdata;
                end
            end
        end

        // resumable flag taken when the stop enters
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                resumable_ff[a] <= 1'b0;
            end else if (stop_cmd) begin
                // a stop landing with a reset still latches, so it sets the flag
                resumable_ff[a] <= cfg_ff[a][aesl_pkg::CFG_RESUME_ALLOW]; // [RULE_19]
            end else if (reset_cmd) begin
                resumable_ff[a] <= 1'b0;
            end
        end

        // servo loop state and the remembered state before the stop
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                loop_ff[a] <= 1'b0;
                loop_before_ff[a] <= 1'b0;
            end else if (nxt_cause[aesl_pkg::BIT_SUMMARY]) begin
                // any cause still present after this edge keeps the loop open,
                // even when a reset lands in the same cycle
                if (!cause_ff[a][aesl_pkg::BIT_SUMMARY]) begin
                    loop_before_ff[a] <= loop_ff[a];
                end
                loop_ff[a] <= 1'b0; // [RULE_18]
            end else if (reset_cmd) begin
                loop_ff[a] <= loop_before_ff[a]; // [RULE_17]
            end else if (hit) begin
                if (cmd.loop_close_cmd) begin
                    loop_ff[a] <= 1'b1;
                end else if (cmd.loop_open_cmd) begin
                    loop_ff[a] <= 1'b0;
                end
            end
        end

        // one-cycle queue flush on a non-resumable reset
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                flush_ff[a] <= 1'b0;
            end else begin
                flush_ff[a] <= reset_cmd & cause_ff[a][aesl_pkg::BIT_SUMMARY]
                    & !resumable_ff[a]; // [RULE_15] [RULE_16]
            end
        end

        // drive outputs
        always_comb begin
            drive[a].loop_closed = loop_ff[a];
            drive[a].stop_active = cause_ff[a][aesl_pkg::BIT_SUMMARY];
            drive[a].output_zero = cause_ff[a][aesl_pkg::BIT_SUMMARY]; // [RULE_18]
            drive[a].stepper_zero = cause_ff[a][aesl_pkg::BIT_SUMMARY]
                && kind == aesl_pkg::AESL_STEPPER; // [RULE_11]
            drive[a].resume_mode = resumable_ff[a] & cause_ff[a][aesl_pkg::BIT_SUMMARY]; // [RULE_19]
            drive[a].queue_flush = flush_ff[a]; // [RULE_16]
        end
    end

endmodule

// [design/aesl_pkg.sv]
// package: register map, cause codes and shared types for the axis emergency-stop latch
package aesl_pkg;

    // register byte offsets
    localparam logic [11:0] ADDR_CAUSE_WORD = 12'h000;
    localparam logic [11:0] ADDR_AXIS_CFG = 12'h004;
    localparam logic [11:0] ADDR_AXIS_STAT = 12'h008;
    localparam logic [11:0] ADDR_FOLLOW_LIMIT = 12'h00C;
    localparam logic [11:0] ADDR_AXIS_SEL = 12'h010;

    // cause word bit positions
    localparam int BIT_FEEDBACK = 0;
    localparam int BIT_FOLLOW = 1;
    localparam int BIT_OVERFLOW = 2;
    localparam int BIT_USER = 3;
    localparam int BIT_DRIVE = 4;
    localparam int BIT_SYNC = 5;
    localparam int BIT_SUMMARY = 15;

    // axis configuration field positions
    localparam int CFG_KIND_LSB = 0;
    localparam int CFG_RESUME_ALLOW = 2;

    // drive status bit that reports a drive-side stop
    localparam int DRIVE_STOP_BIT = 13;

    // overflow limits
    localparam int PRODUCT_BITS = 31;
    localparam int SCALED_BITS = 16;

    // reset values
    localparam logic [15:0] CAUSE_RESET = 16'h0000;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [31:0] LIMIT_RESET = 32'h0000_FFFF;

    // kind of axis
    typedef enum logic [1:0] {
        AESL_SERVO = 2'h0,
        AESL_DIGITIZING = 2'h1,
        AESL_STEPPER = 2'h2,
        AESL_NETWORKED = 2'h3
    } aesl_kind_type;

    // per-axis live measurements from the motion core
    typedef struct packed {
        logic feedback_lost;
        logic sync_lost;
        logic [15:0] drive_status;
        logic signed [31:0] commanded_pos;
        logic signed [31:0] actual_pos;
        logic signed [31:0] leader_moved;
        logic signed [31:0] follower_distance;
        logic signed [31:0] leader_distance;
        logic follower_active;
    } aesl_meas_type;

    // per-axis drive outputs of the latch
    typedef struct packed {
        logic loop_closed;
        logic output_zero;
        logic stepper_zero;
        logic resume_mode;
        logic queue_flush;
        logic stop_active;
    } aesl_drive_type;

    // stop and reset command from the control program
    typedef struct packed {
        logic stop;
        logic reset;
        logic loop_close_cmd;
        logic loop_open_cmd;
        logic [7:0] axis;
    } aesl_cmd_type;

endpackage

// [verification/aesl_top_properties.sv]
// checker: port-level properties of the axis emergency-stop latch
`timescale 1ns/100ps
module aesl_top_properties #(
    parameter int AXES = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire aesl_pkg::aesl_cmd_type cmd,
    input wire logic cmd_done,
    input wire aesl_pkg::aesl_meas_type [AXES-1:0] meas,
    input wire aesl_pkg::aesl_drive_type [AXES-1:0] drive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // stop and reset pulses aimed at axis zero
    sequence s_stop0;
        cmd.stop && cmd.axis == 8'h00;
    endsequence
    sequence s_reset0;
        cmd.reset && cmd.axis == 8'h00;
    endsequence
    // completed read of the cause word
    wire logic cause_rd = psel && penable && !pwrite && paddr == aesl_pkg::ADDR_CAUSE_WORD;
    ////////////////////////////////////////////////////////////////////////////////
    a_done_valid: assert property ((cmd.stop || cmd.reset) && cmd.axis < AXES |-> cmd_done)
        else $error("command not acknowledged");
    a_done_idle: assert property (!(cmd.stop || cmd.reset) |-> !cmd_done)
        else $error("acknowledge without command");
    a_stop_opens: assert property (s_stop0 |=> drive[0].stop_active && !drive[0].loop_closed)
        else $error("stop left the loop closed");
    a_stop_holds: assert property (
        drive[0].stop_active && !(cmd.reset && cmd.axis == 8'h00)
        |=> drive[0].stop_active) else $error("stop dropped without reset");
    a_output_zero: assert property (drive[0].stop_active |-> drive[0].output_zero)
        else $error("output not zero while stopped");
    a_stepper_zero: assert property (drive[0].stepper_zero |-> drive[0].stop_active)
        else $error("stepper zeroed without stop");
    a_flush_kept: assert property (s_reset0 ##0 drive[0].stop_active
        |=> drive[0].queue_flush == !$past(drive[0].resume_mode)) else $error("queue flush wrong");
    a_reset_clears: assert property (s_reset0 ##0 !cmd.stop && meas[0] == '0
        |=> !drive[0].stop_active) else $error("reset did not clear stop");
    a_summary_bit: assert property (cause_rd && !pslverr |-> prdata[15] == (prdata[7:0] != 8'h00)
        && prdata[14:8] == 7'h00) else $error("summary bit disagrees with causes");
endmodule
bind aesl_top aesl_top_properties #(.AXES(AXES)) i_aesl_top_properties (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd(cmd), .cmd_done(cmd_done), .meas(meas), .drive(drive));

// [verification/aesl_prog.sv]
// partner: control program that pulses stop, reset and loop commands
`timescale 1ns/100ps
module aesl_prog (
    input wire logic ref_clk,
    output aesl_pkg::aesl_cmd_type cmd
);
    initial cmd = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle command pulse qualified by an axis, then an idle edge
    task automatic issue(input logic [3:0] f, input logic [7:0] ax);
        cmd <= {f, ax};
        @(posedge ref_clk);
        cmd <= '0;
        @(posedge ref_clk);
    endtask
endmodule

// [verification/tb_axis_emergency_stop_latch.sv]
// testbench: registers, commands and motion inputs of the emergency-stop latch
`timescale 1ns/100ps
module tb_axis_emergency_stop_latch;
    localparam logic [11:0] A_CW = aesl_pkg::ADDR_CAUSE_WORD;
    localparam logic [11:0] A_CFG = aesl_pkg::ADDR_AXIS_CFG;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmd_done;
    aesl_pkg::aesl_cmd_type cmd;
    aesl_pkg::aesl_meas_type [3:0] meas = '0;
    aesl_pkg::aesl_drive_type [3:0] drive;
    logic [32:0] exp_q[$];
    int failures = 0;
    int compares = 0;
    int flushes = 0;
    int cyc = 0;
    always #2.5 ref_clk = ~ref_clk;
    aesl_top #(.AXES(4)) i_aesl_top (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd(cmd), .cmd_done(cmd_done), .meas(meas),
        .drive(drive));
    aesl_prog i_aesl_prog (.ref_clk(ref_clk), .cmd(cmd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one transfer: setup, access held until pready, release, idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic aesl_pkg::aesl_meas_type mk(input logic [2:0] f, input logic [31:0] cp,
        lm, fd, ld);
        return '{f[2], f[1], {2'h0, f[0], 13'h0000}, cp, 32'h0, lm, fd, ld, fd != 32'h0};
    endfunction
    // hold a measured condition on axis zero for two edges
    task automatic hit(input aesl_pkg::aesl_meas_type m);
        meas[0] <= m;
        repeat (2) @(posedge ref_clk);
        meas[0] <= '0;
        @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // monitor: each read takes the oldest note; counts flush pulses; timeout
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
        if (cmd.stop || cmd.reset) begin
            check(33'(cmd_done), 33'(cmd.axis < 8'h04));
        end
        if (drive[0].queue_flush === 1'b1) flushes++;
        cyc++;
        if (cyc == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    // main sequence
    initial begin
        void'($urandom(62));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(A_CFG, 33'h0);
        rd(aesl_pkg::ADDR_FOLLOW_LIMIT, 33'hFFFF);
        rd(A_CW, 33'h0);
        rd(12'h020, 33'h1_0000_0000);
        apb(1'b1, aesl_pkg::ADDR_AXIS_SEL, 32'h0);
        i_aesl_prog.issue(4'h2, 8'h00);
        i_aesl_prog.issue(4'h8, 8'h00);
        rd(A_CW, 33'h8008);
        rd(aesl_pkg::ADDR_AXIS_STAT, 33'h1);
        repeat (20) @(posedge ref_clk);
        rd(A_CW, 33'h8008);
        i_aesl_prog.issue(4'h4, 8'h00);
        check(33'(drive[0].loop_closed), 33'h1);
        rd(A_CW, 33'h0);
        check(33'(flushes), 33'h1);
        apb(1'b1, A_CFG, 32'h4);
        i_aesl_prog.issue(4'h8, 8'h00);
        check(33'(drive[0].resume_mode), 33'h1);
        i_aesl_prog.issue(4'h4, 8'h00);
        apb(1'b1, A_CFG, 32'h0);
        check(33'(flushes), 33'h1);
        apb(1'b1, aesl_pkg::ADDR_FOLLOW_LIMIT, 32'h10);
        hit(mk(3'h4, 32'h11 + ($urandom % 256), 32'h0, 32'h0, 32'h0));
        rd(A_CW, 33'h8003);
        i_aesl_prog.issue(4'h4, 8'h00);
        hit(mk(3'h0, 32'h0, 32'h8000, 32'h10000, 32'h7FFF_FFFF));
        rd(A_CW, 33'h8004);
        i_aesl_prog.issue(4'h4, 8'h00);
        hit(mk(3'h0, 32'h0, 32'h100, 32'h200, 32'h1));
        rd(A_CW, 33'h8004);
        i_aesl_prog.issue(4'h4, 8'h00);
        apb(1'b1, A_CFG, 32'h3);
        hit(mk(3'h3, 32'h0, 32'h0, 32'h0, 32'h0));
        rd(A_CW, 33'h8030);
        i_aesl_prog.issue(4'h4, 8'h00);
        apb(1'b1, A_CFG, 32'h2);
        hit(mk(3'h4, 32'h7FFF, 32'h0, 32'h0, 32'h0));
        rd(A_CW, 33'h0);
        i_aesl_prog.issue(4'h8, 8'h00);
        check(33'(drive[0].stepper_zero), 33'h1);
        i_aesl_prog.issue(4'h4, 8'h00);
        apb(1'b1, A_CFG, 32'h1);
        hit(mk(3'h7, 32'h7FFF, 32'h0, 32'h0, 32'h0));
        rd(A_CW, 33'h8001);
        i_aesl_prog.issue(4'h4, 8'h00);
        i_aesl_prog.issue(4'h2, 8'h00);
        check(33'(drive[0].loop_closed), 33'h1);
        i_aesl_prog.issue(4'h1, 8'h00);
        check(33'(drive[0].loop_closed), 33'h0);
        i_aesl_prog.issue(4'h8, 8'h05);
        rd(A_CW, 33'h0);
        tally_and_finish();
    end
endmodule
